// ---- trap_vector_dispatch_bench.sv ----
// Self-checking bench for the trap dispatch block.
`default_nettype none
`include "tvd_defines.vh"
module trap_vector_dispatch_bench;
   timeunit 1ns;
   timeprecision 1ps;
   wire power_fail, power_restored, illegal_opcode, reg_mode_jump, stack_limit;
   wire bad_internal_addr, microbreak, ext_func_no_ucs, status_move_unsup, float_op_absent;
   wire user_halt, cache_parity_err, bus_parity_err, cs_parity_err, float_exception;
   wire mmu_abort, return_instr, instr_done, instr_valid;
   logic mclk = 1'b0;
   logic rst, word_access, bus_strobe, bus_reply, mem_ready, mem_req, mem_write;
   logic abort_instr, load_pc_psw, trap_busy, pf_window_open;
   logic [15:0] access_addr, instr_word, cur_pc, processor_status_word, cur_sp;
   logic [15:0] mem_rdata, mem_addr, mem_wdata, new_pc, new_psw, new_sp;
   logic [7:0]  trap_argument;
   logic [3:0]  lat;
   logic [18:0] ev;
   logic [8:0]  vtab [0:15] = '{9'h014, 9'h014, 9'h008, 9'h004, 9'h004, 9'h004, 9'h004,
      9'h008, 9'h008, 9'h008, 9'h008, 9'h04C, 9'h04C, 9'h04C, 9'h0A4, 9'h0A8};
   int errors, checks, aborts;
   assign {instr_valid, instr_done, return_instr, mmu_abort, float_exception, cs_parity_err,
      bus_parity_err, cache_parity_err, user_halt, float_op_absent, status_move_unsup,
      ext_func_no_ucs, microbreak, bad_internal_addr, stack_limit, reg_mode_jump,
      illegal_opcode, power_restored, power_fail} = ev;
   tvd_trap_dispatch #(.PF_WINDOW_CYC(20)) dut_u (.*);
   tvd_mem_model mem_u (.*);
   always #2 mclk = ~mclk;
   always @(posedge mclk)
      if (abort_instr === 1'b1)
         aborts++;
   task automatic conclude;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input int b);
      ev[b] = 1'b1;
      @(negedge mclk);
      ev[b] = 1'b0;
   endtask
   task automatic idle_check(input int n);
      repeat (n) @(negedge mclk);
      check({15'h0000, trap_busy}, 16'h0000);
   endtask
   task automatic wait_load(input logic [15:0] pc, input logic [15:0] psw,
                            input logic [15:0] sp);
      int n;
      n = 0;
      while (load_pc_psw !== 1'b1 && n < 200)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (load_pc_psw !== 1'b1)
      begin
         errors++;
         conclude();
      end
      check(new_pc, pc);
      check(new_psw, psw);
      check(new_sp, sp);
      @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic expect_vec(input logic [8:0] v);
      wait_load(16'hC000 + {8'h00, v[8:1]}, 16'hC001 + {8'h00, v[8:1]}, 16'h03FC);
   endtask
   task automatic t_table;
      for (int b = 0; b < 16; b++)
      begin
         pulse(b);
         if (b == 0)
            check({15'h0000, pf_window_open}, 16'h0001);
         expect_vec(vtab[b]);
      end
      check({15'h0000, pf_window_open}, 16'h0000);
      $display("test table done");
   endtask
   task automatic t_instr;
      logic [15:0] w [4] = '{`TVD_OP_BREAK, `TVD_OP_IO_CALL,
         {`TVD_OP_EMULATOR, 8'hA5}, {`TVD_OP_SW_CALL_HI, 8'h5A}};
      logic [8:0] v [4] = '{9'h00C, 9'h010, 9'h018, 9'h01C};
      for (int i = 0; i < 4; i++)
      begin
         instr_word = w[i];
         pulse(18);
         expect_vec(v[i]);
         if (i > 1)
            check({8'h00, trap_argument}, {8'h00, w[i][7:0]});
      end
      $display("test instr done");
   endtask
   task automatic t_bus;
      aborts = 0;
      access_addr = 16'h1000;
      word_access = 1'b1;
      @(negedge mclk);
      word_access = 1'b0;
      idle_check(8);
      access_addr = 16'h1001;
      word_access = 1'b1;
      @(negedge mclk);
      word_access = 1'b0;
      expect_vec(9'h004);
      bus_strobe = 1'b1;
      repeat (30) @(negedge mclk);
      bus_reply = 1'b1;
      @(negedge mclk);
      bus_strobe = 1'b0;
      bus_reply = 1'b0;
      idle_check(70);
      bus_strobe = 1'b1;
      expect_vec(9'h004);
      bus_strobe = 1'b0;
      check(16'(aborts), 16'h0002);
      $display("test bus done");
   endtask
   task automatic t_trace;
      instr_word = 16'h1234;
      processor_status_word = 16'h0010;
      pulse(18);
      pulse(17);
      expect_vec(9'h00C);
      processor_status_word = 16'h0000;
      pulse(18);
      pulse(17);
      idle_check(10);
      $display("test trace done");
   endtask
   task automatic t_prio_ret;
      lat = 4'h3;
      ev[14] = 1'b1;
      pulse(2);
      ev[14] = 1'b0;
      expect_vec(9'h008);
      expect_vec(9'h0A4);
      pulse(16);
      wait_load(16'hC200, 16'hC201, 16'h0404);
      pulse(0);
      pulse(16);
      expect_vec(9'h014);
      idle_check(10);
      $display("test priority and return done");
   endtask
   initial
   begin
      rst = 1'b1;
      ev = '0;
      {word_access, bus_strobe, bus_reply} = 3'h0;
      access_addr = 16'h0000;
      instr_word = 16'h0000;
      cur_pc = 16'h1234;
      processor_status_word = 16'h0000;
      cur_sp = 16'h0400;
      lat = 4'h0;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_table();
      t_instr();
      t_bus();
      t_trace();
      t_prio_ret();
      conclude();
   end
endmodule // trap_vector_dispatch_bench
`default_nettype wire

// ---- tvd_defines.vh ----
// Constants for the trap and exception dispatch block.
// Contract
// - Power fail traps through 24 and leaves the handler a 2 ms save window.
// - Power restore traps again through 24 to run the power-up routine.
// - A word access at an odd byte address aborts and traps through 4.
// - A bus strobe with no slave reply in time aborts and traps through 4.
// - Illegal or reserved opcodes trap through 10.
// - Trap entry pushes program counter and status word, then loads the vector pair.
// - Interrupt return and trace return pop and restore counter and status word.
// - Emulator call and software call ignore their low byte, left for the handler.
// - Fixed vectors: 000 reserved, 014 breakpoint, 020 io call, 030 emulator, 034 call.
// - Vector 4 also serves register-mode jumps, stack limits, internal address, microbreak.
// - Vector 10 also serves extended function, status moves, absent float ops, user halt.
// - Cache, bus memory and control store parity errors trap through 114.
// - Float exceptions trap through 244; memory management aborts through 250.
`ifndef TVD_DEFINES_VH
`define TVD_DEFINES_VH

`define TVD_VEC_W         9
`define TVD_VEC_RESERVED  9'h000
`define TVD_VEC_CPU_ERR   9'h004
`define TVD_VEC_ILL_INSTR 9'h008
`define TVD_VEC_BREAK     9'h00C
`define TVD_VEC_IO_CALL   9'h010
`define TVD_VEC_POWER     9'h014
`define TVD_VEC_EMULATOR  9'h018
`define TVD_VEC_SW_CALL   9'h01C
`define TVD_VEC_PARITY    9'h04C
`define TVD_VEC_FLOAT     9'h0A4
`define TVD_VEC_MMU       9'h0A8

`define TVD_NSRC          11
`define TVD_SRC_POWER     0
`define TVD_SRC_BUS_ERR   1
`define TVD_SRC_CPU_ERR   2
`define TVD_SRC_MMU       3
`define TVD_SRC_PARITY    4
`define TVD_SRC_ILL_INSTR 5
`define TVD_SRC_FLOAT     6
`define TVD_SRC_SW_TRAP   7
`define TVD_SRC_IO_CALL   8
`define TVD_SRC_BREAK     9
`define TVD_SRC_TRACE     10

`define TVD_IDX_W         4

`define TVD_OP_EMULATOR   8'h88
`define TVD_OP_SW_CALL_HI 8'h89
`define TVD_OP_BREAK      16'h0003
`define TVD_OP_IO_CALL    16'h0004
`define TVD_PSW_TRACE     4

`define TVD_PF_WINDOW_NS  2000000
`define TVD_CLK_NS        4
`define TVD_PF_WINDOW_CYC (`TVD_PF_WINDOW_NS / `TVD_CLK_NS)
`define TVD_PF_CNT_W      20

`define TVD_BUS_TIMEOUT   64
`define TVD_BUS_CNT_W     7

`define TVD_STACK_STEP    16'h0002

`endif

// ---- tvd_mem_model.sv ----
// Memory and stack partner that answers the dispatch block's accesses.
`default_nettype none
module tvd_mem_model
(
   input  wire logic        mclk,
   input  wire logic [3:0]  lat,
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output var  logic        mem_ready,
   output var  logic [15:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:1023];
   logic [3:0]  wait_r;
   initial
   begin
      mem_ready = 1'b0;
      mem_rdata = 16'h0000;
      wait_r = 4'h0;
      for (int i = 0; i < 1024; i++)
         mem[i] = 16'hC000 + 16'(i);
   end
   always @(posedge mclk)
   begin
      mem_ready <= 1'b0;
      // The data lines are not held between answers, so stale data cannot pass.
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ready)
      begin
         if (wait_r == lat)
         begin
            wait_r <= 4'h0;
            mem_ready <= 1'b1;
            if (mem_write)
               mem[mem_addr[10:1]] <= mem_wdata;
            else
               mem_rdata <= mem[mem_addr[10:1]];
         end
         else
            wait_r <= wait_r + 4'h1;
      end
   end
endmodule // tvd_mem_model
`default_nettype wire

// ---- tvd_pending_bit.v ----
// One sticky pending trap condition, served once and then cleared.
`default_nettype none

module tvd_pending_bit
(
   input  wire mclk,
   input  wire rst,
   input  wire set,
   input  wire clr,
   output wire pend
);

   reg pend_r;

   // A new event in the clearing cycle keeps the bit set so it is not lost.
   always @(posedge mclk)
   begin
      if (rst)
         pend_r <= 1'b0;
      else if (set)
         pend_r <= 1'b1;
      else if (clr)
         pend_r <= 1'b0;
   end

   assign pend = pend_r;

endmodule // tvd_pending_bit

`default_nettype wire

// ---- tvd_trap_dispatch.v ----
// Trap and exception dispatch: detects trap causes, pushes state, loads vectors.
`default_nettype none
`include "tvd_defines.vh"

module tvd_trap_dispatch
#(
   parameter PF_WINDOW_CYC = `TVD_PF_WINDOW_CYC
)
(
   input  wire        mclk,
   input  wire        rst,
   input  wire        power_fail,
   input  wire        power_restored,
   input  wire        word_access,
   input  wire [15:0] access_addr,
   input  wire        bus_strobe,
   input  wire        bus_reply,
   input  wire        instr_valid,
   input  wire [15:0] instr_word,
   input  wire        instr_done,
   input  wire        illegal_opcode,
   input  wire        reg_mode_jump,
   input  wire        stack_limit,
   input  wire        bad_internal_addr,
   input  wire        microbreak,
   input  wire        ext_func_no_ucs,
   input  wire        status_move_unsup,
   input  wire        float_op_absent,
   input  wire        user_halt,
   input  wire        cache_parity_err,
   input  wire        bus_parity_err,
   input  wire        cs_parity_err,
   input  wire        float_exception,
   input  wire        mmu_abort,
   input  wire        return_instr,
   input  wire [15:0] cur_pc,
   input  wire [15:0] processor_status_word,
   input  wire [15:0] cur_sp,
   input  wire        mem_ready,
   input  wire [15:0] mem_rdata,
   output reg         mem_req,
   output reg         mem_write,
   output reg  [15:0] mem_addr,
   output reg  [15:0] mem_wdata,
   output reg         abort_instr,
   output reg         load_pc_psw,
   output reg  [15:0] new_pc,
   output reg  [15:0] new_psw,
   output reg  [15:0] new_sp,
   output wire        trap_busy,
   output reg  [7:0]  trap_argument,
   output reg         pf_window_open
);

   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_PUSH1 = 6'h02;
   localparam [5:0] ST_PUSH2 = 6'h04;
   localparam [5:0] ST_VEC1  = 6'h08;
   localparam [5:0] ST_VEC2  = 6'h10;
   localparam [5:0] ST_POP   = 6'h20;

   reg  [5:0]                 state_r;
   reg  [5:0]                 state_nxt;
   reg                        pop_second_r;
   reg  [`TVD_VEC_W-1:0]      vec_r;
   reg  [`TVD_IDX_W-1:0]      src_r;
   reg  [15:0]                sp_r;
   reg  [15:0]                saved_pc_r;
   reg  [15:0]                saved_psw_r;
   reg  [`TVD_BUS_CNT_W-1:0]  bus_cnt_r;
   reg  [`TVD_PF_CNT_W-1:0]   pf_cnt_r;
   reg                        trace_armed_r;

   wire [`TVD_NSRC-1:0] set_vec;
   wire [`TVD_NSRC-1:0] pend_vec;
   reg  [`TVD_NSRC-1:0] clr_vec;
   reg  [`TVD_IDX_W-1:0] win_idx;
   reg                  win_any;
   reg  [`TVD_VEC_W-1:0] win_vec;
   integer              i;

   wire odd_word  = word_access & access_addr[0];
   wire bus_tmo   = bus_strobe & ~bus_reply & (bus_cnt_r == `TVD_BUS_TIMEOUT);
   // Only the high byte decides the emulator and software-call opcodes; the low byte is the argument.
   wire is_emu    = instr_valid & (instr_word[15:8] == `TVD_OP_EMULATOR);
   wire is_swc    = instr_valid & (instr_word[15:8] == `TVD_OP_SW_CALL_HI);
   wire is_brk    = instr_valid & (instr_word == `TVD_OP_BREAK);
   wire is_ioc    = instr_valid & (instr_word == `TVD_OP_IO_CALL);

   assign set_vec[`TVD_SRC_POWER]     = power_fail | power_restored;
   assign set_vec[`TVD_SRC_BUS_ERR]   = odd_word | bus_tmo;
   assign set_vec[`TVD_SRC_CPU_ERR]   = reg_mode_jump | stack_limit | bad_internal_addr
                                        | microbreak;
   assign set_vec[`TVD_SRC_MMU]       = mmu_abort;
   assign set_vec[`TVD_SRC_PARITY]    = cache_parity_err | bus_parity_err | cs_parity_err;
   assign set_vec[`TVD_SRC_ILL_INSTR] = illegal_opcode | ext_func_no_ucs | status_move_unsup
                                        | float_op_absent | user_halt;
   assign set_vec[`TVD_SRC_FLOAT]     = float_exception;
   assign set_vec[`TVD_SRC_SW_TRAP]   = is_emu | is_swc;
   assign set_vec[`TVD_SRC_IO_CALL]   = is_ioc;
   assign set_vec[`TVD_SRC_BREAK]     = is_brk;
   assign set_vec[`TVD_SRC_TRACE]     = instr_done & trace_armed_r;

   genvar g;
   generate
      for (g = 0; g < `TVD_NSRC; g = g + 1)
      begin : g_pend
         tvd_pending_bit u_pend
         (
            .mclk (mclk),
            .rst  (rst),
            .set  (set_vec[g]),
            .clr  (clr_vec[g]),
            .pend (pend_vec[g])
         );
      end
   endgenerate

   // Lowest index wins: power, then bus errors, down to trace last.
   always @*
   begin
      win_idx = {`TVD_IDX_W{1'b0}};
      win_any = 1'b0;
      for (i = `TVD_NSRC - 1; i >= 0; i = i - 1)
      begin
         if (pend_vec[i])
         begin
            win_idx = i[`TVD_IDX_W-1:0];
            win_any = 1'b1;
         end
      end
   end

   // The emulator and software-call pair share one pending bit; the vector is picked later.
   reg sw_is_call_r;

   always @*
   begin
      case (win_idx)
         `TVD_SRC_POWER:     win_vec = `TVD_VEC_POWER;
         `TVD_SRC_BUS_ERR:   win_vec = `TVD_VEC_CPU_ERR;
         `TVD_SRC_CPU_ERR:   win_vec = `TVD_VEC_CPU_ERR;
         `TVD_SRC_MMU:       win_vec = `TVD_VEC_MMU;
         `TVD_SRC_PARITY:    win_vec = `TVD_VEC_PARITY;
         `TVD_SRC_ILL_INSTR: win_vec = `TVD_VEC_ILL_INSTR;
         `TVD_SRC_FLOAT:     win_vec = `TVD_VEC_FLOAT;
         `TVD_SRC_SW_TRAP:   win_vec = sw_is_call_r ? `TVD_VEC_SW_CALL
                                                    : `TVD_VEC_EMULATOR;
         `TVD_SRC_IO_CALL:   win_vec = `TVD_VEC_IO_CALL;
         `TVD_SRC_BREAK:     win_vec = `TVD_VEC_BREAK;
         `TVD_SRC_TRACE:     win_vec = `TVD_VEC_BREAK;
         default:            win_vec = `TVD_VEC_RESERVED;
      endcase
   end

   wire take_trap = (state_r == ST_IDLE) & win_any;
   wire take_ret  = (state_r == ST_IDLE) & ~win_any & return_instr;

   always @*
   begin
      clr_vec   = {`TVD_NSRC{1'b0}};
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (take_trap)
            begin
               state_nxt = ST_PUSH1;
               clr_vec[win_idx] = 1'b1;
            end
            else if (take_ret)
               state_nxt = ST_POP;
         end
         ST_PUSH1: if (mem_ready) state_nxt = ST_PUSH2;
         ST_PUSH2: if (mem_ready) state_nxt = ST_VEC1;
         ST_VEC1:  if (mem_ready) state_nxt = ST_VEC2;
         ST_VEC2:  if (mem_ready) state_nxt = ST_IDLE;
         ST_POP:   if (mem_ready & pop_second_r) state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   // Memory command follows the state; status word goes first so the counter is on top.
   always @*
   begin
      mem_req   = 1'b0;
      mem_write = 1'b0;
      mem_addr  = 16'h0000;
      mem_wdata = 16'h0000;
      case (state_r)
         ST_PUSH1:
         begin
            mem_req   = 1'b1;
            mem_write = 1'b1;
            mem_addr  = sp_r - `TVD_STACK_STEP;
            mem_wdata = saved_psw_r;
         end
         ST_PUSH2:
         begin
            mem_req   = 1'b1;
            mem_write = 1'b1;
            mem_addr  = sp_r - `TVD_STACK_STEP;
            mem_wdata = saved_pc_r;
         end
         ST_VEC1:
         begin
            mem_req  = 1'b1;
            mem_addr = {7'h00, vec_r};
         end
         ST_VEC2:
         begin
            mem_req  = 1'b1;
            mem_addr = {7'h00, vec_r} + `TVD_STACK_STEP;
         end
         ST_POP:
         begin
            mem_req  = 1'b1;
            mem_addr = sp_r;
         end
         default: mem_req = 1'b0;
      endcase
   end

   assign trap_busy = (state_r != ST_IDLE);

   always @(posedge mclk)
   begin
      if (rst)
      begin
         state_r       <= ST_IDLE;
         pop_second_r  <= 1'b0;
         vec_r         <= `TVD_VEC_RESERVED;
         src_r         <= {`TVD_IDX_W{1'b0}};
         sp_r          <= 16'h0000;
         saved_pc_r    <= 16'h0000;
         saved_psw_r   <= 16'h0000;
         sw_is_call_r  <= 1'b0;
         trap_argument <= 8'h00;
         abort_instr   <= 1'b0;
         load_pc_psw   <= 1'b0;
         new_pc        <= 16'h0000;
         new_psw       <= 16'h0000;
         new_sp        <= 16'h0000;
         trace_armed_r <= 1'b0;
      end
      else
      begin
         state_r     <= state_nxt;
         abort_instr <= 1'b0;
         load_pc_psw <= 1'b0;
         // Trace arms from the status word held at the start of the instruction.
         if (instr_valid)
            trace_armed_r <= processor_status_word[`TVD_PSW_TRACE];
         // A call arriving as the previous one is taken must still record its own argument.
         if ((is_emu | is_swc) & (~pend_vec[`TVD_SRC_SW_TRAP] | clr_vec[`TVD_SRC_SW_TRAP]))
         begin
            sw_is_call_r  <= is_swc;
            trap_argument <= instr_word[7:0];
         end
         if (take_trap)
         begin
            vec_r       <= win_vec;
            src_r       <= win_idx;
            sp_r        <= cur_sp;
            saved_pc_r  <= cur_pc;
            saved_psw_r <= processor_status_word;
            abort_instr <= (win_idx == `TVD_SRC_BUS_ERR);
         end
         if (take_ret)
         begin
            sp_r         <= cur_sp;
            pop_second_r <= 1'b0;
         end
         if (mem_ready)
         begin
            case (state_r)
               ST_PUSH1: sp_r <= sp_r - `TVD_STACK_STEP;
               ST_PUSH2: sp_r <= sp_r - `TVD_STACK_STEP;
               ST_VEC1:  new_pc <= mem_rdata;
               ST_VEC2:
               begin
                  new_psw     <= mem_rdata;
                  new_sp      <= sp_r;
                  load_pc_psw <= 1'b1;
               end
               ST_POP:
               begin
                  sp_r         <= sp_r + `TVD_STACK_STEP;
                  pop_second_r <= 1'b1;
                  if (pop_second_r)
                  begin
                     new_psw     <= mem_rdata;
                     new_sp      <= sp_r + `TVD_STACK_STEP;
                     load_pc_psw <= 1'b1;
                  end
                  else
                     new_pc <= mem_rdata;
               end
               default: ;
            endcase
         end
      end
   end

   // Bus timeout counter; it parks one past the limit so a held strobe traps only once.
   always @(posedge mclk)
   begin
      if (rst | ~bus_strobe | bus_reply)
         bus_cnt_r <= {`TVD_BUS_CNT_W{1'b0}};
      else if (bus_cnt_r <= `TVD_BUS_TIMEOUT)
         bus_cnt_r <= bus_cnt_r + 1'b1;
   end

   // Save window after power fail; software must halt before it closes.
   always @(posedge mclk)
   begin
      if (rst)
      begin
         pf_cnt_r       <= {`TVD_PF_CNT_W{1'b0}};
         pf_window_open <= 1'b0;
      end
      else if (power_fail)
      begin
         pf_cnt_r       <= PF_WINDOW_CYC[`TVD_PF_CNT_W-1:0];
         pf_window_open <= 1'b1;
      end
      else if (pf_cnt_r != {`TVD_PF_CNT_W{1'b0}})
      begin
         pf_cnt_r       <= pf_cnt_r - 1'b1;
         pf_window_open <= (pf_cnt_r != {{(`TVD_PF_CNT_W-1){1'b0}}, 1'b1});
      end
      else
         pf_window_open <= 1'b0;
   end

endmodule // tvd_trap_dispatch

`default_nettype wire

// ---- tvd_trap_dispatch_sva.sv ----
// Port checker for the trap dispatch block.
`default_nettype none
module tvd_trap_sva
#(
   parameter PF_WINDOW_CYC = 20
)
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        power_fail,
   input wire logic        word_access,
   input wire logic [15:0] access_addr,
   input wire logic        bus_strobe,
   input wire logic        bus_reply,
   input wire logic        instr_valid,
   input wire logic [15:0] instr_word,
   input wire logic [15:0] cur_pc,
   input wire logic [15:0] processor_status_word,
   input wire logic [15:0] cur_sp,
   input wire logic        mem_ready,
   input wire logic        mem_req,
   input wire logic        mem_write,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic        abort_instr,
   input wire logic        load_pc_psw,
   input wire logic [15:0] new_sp,
   input wire logic        trap_busy,
   input wire logic [7:0]  trap_argument,
   input wire logic        pf_window_open
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic [7:0]  strobe_cnt_r;
   logic [19:0] pf_cnt_r;
   always_ff @(posedge mclk)
   begin
      strobe_cnt_r <= (rst || !bus_strobe || bus_reply) ? 8'h00 : strobe_cnt_r + 8'h01;
      pf_cnt_r <= (rst || !pf_window_open) ? 20'h00000 : pf_cnt_r + 20'h00001;
   end
   power_trap_a: assert property (power_fail && !trap_busy
      |-> ##[1:2] trap_busy ##[4:60] load_pc_psw)
      else $error("power fail trap not taken");
   pf_window_a: assert property ($fell(pf_window_open) |-> pf_cnt_r == 20'(PF_WINDOW_CYC))
      else $error("power fail window length wrong");
   odd_abort_a: assert property (word_access && access_addr[0] && !trap_busy && !power_fail
      |-> ##[1:4] abort_instr)
      else $error("odd word access not aborted");
   timeout_abort_a: assert property (strobe_cnt_r == 8'h40 && !trap_busy
      |-> ##[0:6] abort_instr)
      else $error("bus timeout not aborted");
   abort_pulse_a: assert property (abort_instr |-> trap_busy ##1 !abort_instr)
      else $error("abort pulse malformed");
   push_psw_a: assert property ($rose(mem_req) && mem_write
      |-> mem_addr == cur_sp - 16'h0002 && mem_wdata == processor_status_word)
      else $error("status push wrong");
   push_pc_a: assert property (mem_req && mem_write && mem_ready
      && mem_addr == cur_sp - 16'h0002
      |=> mem_req && mem_write && mem_addr == cur_sp - 16'h0004 && mem_wdata == cur_pc)
      else $error("counter push wrong");
   pop_addr_a: assert property ($rose(mem_req) && !mem_write |-> mem_addr == cur_sp)
      else $error("return pop address wrong");
   new_sp_a: assert property ($rose(load_pc_psw)
      |-> new_sp == cur_sp - 16'h0004 || new_sp == cur_sp + 16'h0004)
      else $error("stack pointer result wrong");
   arg_latch_a: assert property (instr_valid && instr_word[15:9] == 7'h44
      |=> trap_argument == $past(instr_word[7:0]))
      else $error("call argument not kept");
endmodule // tvd_trap_sva
bind tvd_trap_dispatch tvd_trap_sva #(.PF_WINDOW_CYC(PF_WINDOW_CYC)) chk_u (.*);
`default_nettype wire
